/* File: reset_board_model.sv */
// board side: reset pin with pull-up and button, delay pin comparator
`timescale 1ns/1ps
module reset_board_model (
  input wire rst_cfg_pkg::od_pin_t reset_in_n_drv,
  input wire logic button_n,
  input wire logic cap_high,
  output logic reset_in_n_i,
  output logic powerdown_delay_above
);
  // open drain wins, else button or the pull-up decides
  assign reset_in_n_i = reset_in_n_drv.oe ? reset_in_n_drv.o : button_n;
  // capacitor level as commanded by the bench
  assign powerdown_delay_above = cap_high;
endmodule : reset_board_model

/* File: reset_pin_config_latch.sv */
// reset pin control, reset sequencer and start-up configuration latch with axi4-lite registers
// Behaviour
// - reset_out_n low at every reset start
// - reset_out_n stays low until end_init_instr
// - system_config bit 3 enables bidirectional reset
// - every reset sequence clears bidir_reset_enable
// - bidir enable writable only before end_init_instr
// - low delay pin cancels pull, forces async
// - pull reset_in_n low during internal sequence
// - pull-down released before first instruction fetch
// - bidir converts software/watchdog reset to hardware
// - delay pin discharge while reset_in_n low
// - powerdown_config_bit enables delay pin pull-up
// - delay pin level selects async or sync
// - software/watchdog samples high 4..0, low 7..6
// - short skips high 7..5; long/power-on all
// - config high byte into latched_config_reg low
// - high bit1, low bit7 feed system_config
// - bus type, active, latch stretch into bus_config0
// - route latched fields to clock/port logic
// - internal sequence lasts 1024 half periods
// - latch 8 (bypass 6) half periods after release
// - software/watchdog reset clears config bits 5..2
//
// The AXI4-Lite register port and the register addresses were decided locally.
`timescale 1ns/1ps
module reset_pin_config_latch (
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // pins
  input wire logic reset_in_n_i,
  output rst_cfg_pkg::od_pin_t reset_in_n_drv,
  output logic reset_out_n,
  input wire logic powerdown_delay_above,
  output logic powerdown_delay_pulldown,
  output logic powerdown_delay_pullup,
  input wire logic [15:0] config_port,
  input wire logic external_access_pin,
  // cpu side, same clock
  input wire logic sw_reset_req,
  input wire logic wdt_reset_req,
  input wire logic end_init_instr,
  input wire logic pll_bypass,
  output logic cpu_reset_active,
  output rst_cfg_pkg::cfg_route_t cfg_route
);

  // ---------------- pin synchronisers ----------------
  logic [18:0] pin_meta_reg; // first stage, read only by the second
  logic [18:0] pin_sync_reg; // second stage, used by the logic
  logic reset_in_n_s; // synchronised reset_in_n
  logic rpd_above_s; // synchronised comparator, above threshold
  logic ea_s; // synchronised external_access_pin
  logic [15:0] port_s; // synchronised config_port

  // two flops on every asynchronous pin; constants under reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_meta_reg <= 19'h7FFFF;
      pin_sync_reg <= 19'h7FFFF;
    end else begin
      pin_meta_reg <= {reset_in_n_i, powerdown_delay_above, external_access_pin, config_port};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  assign reset_in_n_s = pin_sync_reg[18];
  assign rpd_above_s = pin_sync_reg[17];
  assign ea_s = pin_sync_reg[16];
  assign port_s = pin_sync_reg[15:0];

  // ---------------- reset sequencer ----------------
  rst_cfg_pkg::seq_state_t state_reg, state_next; // sequencer state
  rst_cfg_pkg::reset_kind_t kind_reg, kind_next; // source of current reset
  logic [9:0] cnt_reg, cnt_next; // sequence and latch-delay counter
  logic [9:0] low_cnt_reg, low_cnt_next; // external low time, saturating
  logic pull_reg, pull_next; // reset_in_n open-drain pull active
  logic async_reg, async_next; // reset processed as asynchronous
  logic long_reg, long_next; // latest reset was a long hardware reset
  logic bidir_reg; // bidir_reset_enable, from the register group
  logic seq_start; // a new reset sequence begins this cycle
  logic latch_now; // configuration is sampled this cycle
  logic [9:0] latch_last; // last count of the latch delay

  assign latch_last = pll_bypass ? (rst_cfg_pkg::LATCH_BYP_CYCLES - 10'h001)
                                 : (rst_cfg_pkg::LATCH_CYCLES - 10'h001);

  // next-state logic of the sequencer
  always_comb begin
    state_next = state_reg;
    kind_next = kind_reg;
    cnt_next = cnt_reg;
    low_cnt_next = low_cnt_reg;
    pull_next = pull_reg;
    async_next = async_reg;
    long_next = long_reg;
    seq_start = 1'b0;
    latch_now = 1'b0;
    unique case (state_reg)
      rst_cfg_pkg::ST_INIT, rst_cfg_pkg::ST_RUN: begin
        // a pin reset has precedence over a software or watchdog request
        if (!reset_in_n_s || sw_reset_req || wdt_reset_req) begin
          seq_start = 1'b1;
          state_next = rst_cfg_pkg::ST_SEQ;
          cnt_next = 10'h000;
          low_cnt_next = 10'h000;
          long_next = 1'b0;
          async_next = !rpd_above_s;
          // enabled bidir pulls the pin unless the delay pin is already low
          pull_next = bidir_reg && rpd_above_s;
          if (!reset_in_n_s || bidir_reg) begin
            kind_next = rst_cfg_pkg::KIND_HW;
          end else begin
            kind_next = rst_cfg_pkg::KIND_SW;
          end
        end else if (state_reg == rst_cfg_pkg::ST_INIT && end_init_instr) begin
          state_next = rst_cfg_pkg::ST_RUN;
        end
      end
      rst_cfg_pkg::ST_SEQ: begin
        cnt_next = cnt_reg + 10'h001;
        // only external low time counts; our own pull is not a long reset
        if (!reset_in_n_s && !pull_reg && low_cnt_reg != rst_cfg_pkg::LONG_CYCLES) begin
          low_cnt_next = low_cnt_reg + 10'h001;
        end
        if ((!reset_in_n_s || pull_reg) && !rpd_above_s) begin
          pull_next = 1'b0;
          async_next = 1'b1;
        end
        if (cnt_reg == rst_cfg_pkg::SEQ_CYCLES - 10'h001) begin
          pull_next = 1'b0;
          state_next = rst_cfg_pkg::ST_EXTEND;
          cnt_next = 10'h000;
        end
      end
      rst_cfg_pkg::ST_EXTEND: begin
        // reset is stretched while the pin is held low from outside
        if (cnt_reg != rst_cfg_pkg::SETTLE_CYCLES) begin
          cnt_next = cnt_reg + 10'h001;
        end
        if (!reset_in_n_s && low_cnt_reg != rst_cfg_pkg::LONG_CYCLES) begin
          low_cnt_next = low_cnt_reg + 10'h001;
        end
        if (!reset_in_n_s && !rpd_above_s) begin
          async_next = 1'b1;
        end
        if (cnt_reg == rst_cfg_pkg::SETTLE_CYCLES && reset_in_n_s) begin
          async_next = !rpd_above_s;
          long_next = (kind_reg == rst_cfg_pkg::KIND_HW)
                      && (low_cnt_reg == rst_cfg_pkg::LONG_CYCLES);
          state_next = rst_cfg_pkg::ST_LATCH;
          cnt_next = 10'h000;
        end
      end
      rst_cfg_pkg::ST_LATCH: begin
        cnt_next = cnt_reg + 10'h001;
        if (cnt_reg == latch_last) begin
          latch_now = 1'b1;
          state_next = rst_cfg_pkg::ST_INIT;
          cnt_next = 10'h000;
        end
      end
    endcase
  end

  // sequencer registers; aresetn is the power-on reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= rst_cfg_pkg::ST_SEQ;
      kind_reg <= rst_cfg_pkg::KIND_POR;
      cnt_reg <= 10'h000;
      low_cnt_reg <= 10'h000;
      pull_reg <= 1'b0;
      async_reg <= 1'b1;
      long_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      kind_reg <= kind_next;
      cnt_reg <= cnt_next;
      low_cnt_reg <= low_cnt_next;
      pull_reg <= pull_next;
      async_reg <= async_next;
      long_reg <= long_next;
    end
  end

  // ---------------- configuration and register group ----------------
  logic [15:0] cfg_reg, cfg_next; // all sixteen latched config_port bits
  logic ea_reg, ea_next; // external access level at latch time
  logic bidir_next; // bidir_reset_enable next value
  logic pwd_reg, pwd_next; // powerdown_config_bit
  logic [15:0] sample_mask; // bits sampled by this reset
  logic [15:0] clear_mask; // bits forced to zero by this reset
  logic [15:0] latched_config_reg; // view: high byte of port in low byte
  logic [15:0] system_config_reg; // view of system configuration
  logic [15:0] bus_config_reg0; // view of bus configuration
  logic [15:0] reset_status; // view of sequencer state

  // which bits this reset samples depends on its source
  always_comb begin
    clear_mask = 16'h0000;
    if (kind_reg == rst_cfg_pkg::KIND_SW) begin
      sample_mask = rst_cfg_pkg::MASK_SW;
      clear_mask = rst_cfg_pkg::CLEAR_SW;
    end else if (kind_reg == rst_cfg_pkg::KIND_HW && !long_reg) begin
      sample_mask = rst_cfg_pkg::MASK_SHORT;
    end else begin
      sample_mask = rst_cfg_pkg::MASK_ALL;
    end
  end

  // axi handshake state
  logic aw_held_reg, aw_held_next; // write address captured
  logic [3:0] aw_addr_reg, aw_addr_next; // captured write address
  logic w_held_reg, w_held_next; // write data captured
  logic [31:0] w_data_reg, w_data_next; // captured write data
  logic [3:0] w_strb_reg, w_strb_next; // captured byte enables
  logic bvalid_reg, bvalid_next; // write response pending
  logic [1:0] bresp_reg, bresp_next; // write response code
  logic rvalid_reg, rvalid_next; // read data pending
  logic [1:0] rresp_reg, rresp_next; // read response code
  logic [31:0] rdata_reg, rdata_next; // read data
  logic do_write; // both halves present, perform the write

  assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;

  // register views built from stored state
  always_comb begin
    latched_config_reg = {8'h00, cfg_reg[15:8]};
    system_config_reg = 16'h0000;
    system_config_reg[rst_cfg_pkg::SYS_BIDIR_BIT] = bidir_reg;
    system_config_reg[rst_cfg_pkg::SYS_PWD_BIT] = pwd_reg;
    system_config_reg[rst_cfg_pkg::SYS_WRITE_SIGNAL_CONFIG_BIT] = cfg_reg[rst_cfg_pkg::CP_WRITE_SIGNAL_CONFIG_BIT];
    system_config_reg[rst_cfg_pkg::SYS_BYTE_HIGH_DISABLE_BIT] = cfg_reg[rst_cfg_pkg::CP_BYTE_HIGH_DISABLE_BIT];
    bus_config_reg0 = 16'h0000;
    bus_config_reg0[rst_cfg_pkg::BUS_TYPE_LSB +: 2] = cfg_reg[rst_cfg_pkg::CP_BUS_TYPE_PINS_LSB +: 2];
    bus_config_reg0[rst_cfg_pkg::BUS_ACTIVE_BIT] = ea_reg;
    bus_config_reg0[rst_cfg_pkg::BUS_LATCH_BIT] = ea_reg;
    reset_status = 16'h0000;
    reset_status[rst_cfg_pkg::STAT_ASYNC_BIT] = async_reg;
    reset_status[rst_cfg_pkg::STAT_KIND_LSB +: 2] = kind_reg;
    reset_status[rst_cfg_pkg::STAT_LONG_BIT] = long_reg;
    reset_status[rst_cfg_pkg::STAT_OUT_BIT] = reset_out_n;
    reset_status[rst_cfg_pkg::STAT_PULL_BIT] = pull_reg;
    reset_status[rst_cfg_pkg::STAT_STATE_LSB +: 5] = state_reg;
  end

  // next values of configuration, system bits and the bus slave
  always_comb begin
    cfg_next = cfg_reg;
    ea_next = ea_reg;
    bidir_next = bidir_reg;
    pwd_next = pwd_reg;
    aw_held_next = aw_held_reg;
    aw_addr_next = aw_addr_reg;
    w_held_next = w_held_reg;
    w_data_next = w_data_reg;
    w_strb_next = w_strb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rresp_next = rresp_reg;
    rdata_next = rdata_reg;
    if (latch_now) begin
      cfg_next = (cfg_reg & ~sample_mask & ~clear_mask) | (port_s & sample_mask);
      ea_next = ea_s;
    end
    // address and data are taken independently, in either order
    if (s_axi_awvalid && s_axi_awready) begin
      aw_held_next = 1'b1;
      aw_addr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_held_next = 1'b1;
      w_data_next = s_axi_wdata;
      w_strb_next = s_axi_wstrb;
    end
    if (do_write) begin
      aw_held_next = 1'b0;
      w_held_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = rst_cfg_pkg::RESP_OKAY;
      unique case (aw_addr_reg)
        rst_cfg_pkg::OFS_SYSTEM_CONFIG: begin
          if (w_strb_reg[0]) begin
            // after init the enable bit is frozen; late software cannot arm it
            if (state_reg == rst_cfg_pkg::ST_INIT) begin
              bidir_next = w_data_reg[rst_cfg_pkg::SYS_BIDIR_BIT];
            end
            pwd_next = w_data_reg[rst_cfg_pkg::SYS_PWD_BIT];
          end
        end
        rst_cfg_pkg::OFS_LATCHED_CONFIG, rst_cfg_pkg::OFS_BUS_CONFIG0,
        rst_cfg_pkg::OFS_RESET_STATUS: begin
          // read-only: write accepted and dropped
        end
        default: begin
          bresp_next = rst_cfg_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (seq_start) begin
      bidir_next = 1'b0;
    end
    if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_next = 1'b1;
      rresp_next = rst_cfg_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        rst_cfg_pkg::OFS_LATCHED_CONFIG: rdata_next = {16'h0000, latched_config_reg};
        rst_cfg_pkg::OFS_SYSTEM_CONFIG: rdata_next = {16'h0000, system_config_reg};
        rst_cfg_pkg::OFS_BUS_CONFIG0: rdata_next = {16'h0000, bus_config_reg0};
        rst_cfg_pkg::OFS_RESET_STATUS: rdata_next = {16'h0000, reset_status};
        default: begin
          rdata_next = 32'h00000000;
          rresp_next = rst_cfg_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
  end

  // configuration and bus registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_reg <= rst_cfg_pkg::CFG_RESET;
      ea_reg <= 1'b0;
      bidir_reg <= 1'b0;
      pwd_reg <= 1'b0;
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 4'h0;
      w_held_reg <= 1'b0;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= 2'h0;
      rvalid_reg <= 1'b0;
      rresp_reg <= 2'h0;
      rdata_reg <= 32'h00000000;
    end else begin
      cfg_reg <= cfg_next;
      ea_reg <= ea_next;
      bidir_reg <= bidir_next;
      pwd_reg <= pwd_next;
      aw_held_reg <= aw_held_next;
      aw_addr_reg <= aw_addr_next;
      w_held_reg <= w_held_next;
      w_data_reg <= w_data_next;
      w_strb_reg <= w_strb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
    end
  end

  // ---------------- outputs ----------------
  // one slot per channel; no new address until the previous write is answered
  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready = !w_held_reg && !bvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;

  // open drain: level is always low, only the enable moves
  assign reset_in_n_drv.o = 1'b0;
  assign reset_in_n_drv.oe = pull_reg;
  assign reset_out_n = (state_reg == rst_cfg_pkg::ST_RUN);
  assign cpu_reset_active = (state_reg != rst_cfg_pkg::ST_INIT)
                            && (state_reg != rst_cfg_pkg::ST_RUN);
  assign powerdown_delay_pulldown = !reset_in_n_s;
  assign powerdown_delay_pullup = pwd_reg && reset_in_n_s && !cpu_reset_active;

  // latched fields to clock generator, port 4, port 6 and core logic
  assign cfg_route.clock_config_field = cfg_reg[15:13];
  assign cfg_route.segment_addr_select = cfg_reg[12:11];
  assign cfg_route.chip_select_count = cfg_reg[10:9];
  assign cfg_route.bootstrap_select = cfg_reg[rst_cfg_pkg::CP_BSL_BIT];
  assign cfg_route.adapt_mode_select = cfg_reg[rst_cfg_pkg::CP_ADP_BIT];
  assign cfg_route.debug_host_mode_select = cfg_reg[rst_cfg_pkg::CP_EMU_BIT];

endmodule : reset_pin_config_latch

/* File: reset_pin_config_latch_sva.sv */
// checker: port-level properties of the reset pin and configuration latch
`timescale 1ns/1ps
module reset_pin_config_latch_sva (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic reset_in_n_i,
  input wire rst_cfg_pkg::od_pin_t reset_in_n_drv,
  input wire logic reset_out_n,
  input wire logic powerdown_delay_above,
  input wire logic powerdown_delay_pulldown,
  input wire logic powerdown_delay_pullup,
  input wire logic sw_reset_req,
  input wire logic wdt_reset_req,
  input wire logic end_init_instr,
  input wire logic cpu_reset_active,
  input wire rst_cfg_pkg::cfg_route_t cfg_route
);
  logic [9:0] pull_cnt_reg; // consecutive cycles the pin is pulled
  logic [9:0] pull_cnt_next;
  // count the pull length, too long for a repetition
  always_comb begin
    pull_cnt_next = reset_in_n_drv.oe ? pull_cnt_reg + 10'h001 : 10'h000;
  end
  always_ff @(posedge aclk) begin
    pull_cnt_reg <= aresetn ? pull_cnt_next : 10'h000;
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // pin levels held long enough to pass the synchroniser
  sequence pin_low4; !reset_in_n_i [*4]; endsequence
  sequence pin_high4; reset_in_n_i [*4]; endsequence
  sequence seq_begin; !reset_out_n && cpu_reset_active; endsequence
  a_out_low_seq: assert property (cpu_reset_active |-> !reset_out_n)
    else $error("reset output high in sequence");
  a_out_rise_init: assert property ($rose(reset_out_n) |-> $past(end_init_instr))
    else $error("reset output released without end of init");
  a_req_starts: assert property ((sw_reset_req || wdt_reset_req) && !cpu_reset_active |=> seq_begin)
    else $error("request did not start a sequence");
  a_pull_in_seq: assert property (reset_in_n_drv.oe |-> cpu_reset_active)
    else $error("pin pulled outside the sequence");
  // only with the delay pin high, a low one cuts the pull short
  a_pull_length: assert property ($fell(reset_in_n_drv.oe) && powerdown_delay_above
    |-> pull_cnt_reg inside {[511:513]})
    else $error("pull length wrong");
  a_disch_on: assert property (pin_low4 |-> powerdown_delay_pulldown)
    else $error("discharge off with pin low");
  a_disch_off: assert property (pin_high4 |-> !powerdown_delay_pulldown)
    else $error("discharge on with pin high");
  a_pullup_after: assert property (powerdown_delay_pullup |-> !cpu_reset_active)
    else $error("pull-up on during sequence");
  a_route_hold: assert property (!cpu_reset_active && !$past(cpu_reset_active)
    |-> $stable(cfg_route))
    else $error("routed config moved outside latch");
endmodule : reset_pin_config_latch_sva
bind reset_pin_config_latch reset_pin_config_latch_sva reset_pin_config_latch_sva_i (.*);

/* File: reset_pin_config_latch_test.sv */
// testbench: register bus and reset scenarios for the configuration latch
`timescale 1ns/1ps
module reset_pin_config_latch_test;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] s_axi_awaddr = 4'h0;
  logic [3:0] s_axi_araddr = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic reset_in_n_i, reset_out_n, powerdown_delay_above, cpu_reset_active;
  logic powerdown_delay_pulldown, powerdown_delay_pullup;
  rst_cfg_pkg::od_pin_t reset_in_n_drv;
  rst_cfg_pkg::cfg_route_t cfg_route;
  logic [15:0] config_port = 16'hF0FF; // power-on strap pattern
  logic external_access_pin = 1'b1;
  logic sw_reset_req = 1'b0, wdt_reset_req = 1'b0, end_init_instr = 1'b0, pll_bypass = 1'b0;
  logic button_n = 1'b1; // board reset button
  logic cap_high = 1'b0; // delay pin capacitor, empty at power-on
  logic [15:0] exp_cfg; // expected latched configuration
  logic [31:0] d;
  int n_errors = 0;
  int tests_run = 0;
  reset_pin_config_latch reset_pin_config_latch_i (.*);
  reset_board_model reset_board_model_i (.reset_in_n_drv(reset_in_n_drv),
    .button_n(button_n), .cap_high(cap_high), .reset_in_n_i(reset_in_n_i),
    .powerdown_delay_above(powerdown_delay_above));
  // 250 MHz clock
  always #2 aclk = ~aclk;
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task end_of_test;
    $display("errors=%0d checks=%0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_of_test
  // write: address and data offered together, each dropped when taken
  task wr(input logic [3:0] a, input logic [31:0] v, input logic [1:0] er);
    logic ta, tw, tb;
    ta = 0; tw = 0; tb = 0;
    @(posedge aclk);
    s_axi_awaddr <= a; s_axi_wdata <= v; s_axi_bready <= 1;
    s_axi_awvalid <= 1; s_axi_wvalid <= 1;
    while (!tb) begin
      @(posedge aclk);
      if (!ta && s_axi_awready) begin ta = 1; s_axi_awvalid <= 0; end
      if (!tw && s_axi_wready) begin tw = 1; s_axi_wvalid <= 0; end
      if (s_axi_bvalid) begin tb = 1; s_axi_bready <= 0; chk(32'(s_axi_bresp), 32'(er)); end
    end
  endtask : wr
  // read: response code checked here, data handed back
  task rd(input logic [3:0] a, input logic [1:0] er);
    logic ta, tr;
    ta = 0; tr = 0;
    @(posedge aclk);
    s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
    while (!tr) begin
      @(posedge aclk);
      if (!ta && s_axi_arready) begin ta = 1; s_axi_arvalid <= 0; end
      if (s_axi_rvalid) begin tr = 1; d = s_axi_rdata; s_axi_rready <= 0; chk(32'(s_axi_rresp), 32'(er)); end
    end
  endtask : rd
  // bounded wait for the sequence and latch to finish
  task wait_done;
    for (int i = 0; i < 3000 && cpu_reset_active !== 1'b0; i++) @(posedge aclk);
    chk({31'h0, cpu_reset_active}, 32'h0);
  endtask : wait_done
  // compare every visible copy of the latched configuration
  task check_all(input logic [3:0] st, input logic [31:0] m);
    rd(4'h0, 2'h0); chk(d, {24'h0, exp_cfg[15:8]});
    rd(4'h4, 2'h0); chk(d & 32'h288, {22'h0, exp_cfg[9], 1'b0, exp_cfg[7], 7'h0});
    rd(4'h8, 2'h0); chk(d & 32'h6C0, {21'h0, {2{external_access_pin}}, 1'b0, exp_cfg[7:6], 6'h0});
    rd(4'hC, 2'h0); chk(d & m, 32'(st));
    chk({22'h0, cfg_route}, {22'h0, exp_cfg[15:9], exp_cfg[4], exp_cfg[1], exp_cfg[0]});
    chk({31'h0, reset_out_n}, 32'h0);
  endtask : check_all
  // one reset: 0 software, 1 watchdog, 2 short press, 3 long press
  task run(input int how, input logic bidir, input logic [15:0] cp, input logic [15:0] mask,
           input logic [3:0] st);
    wr(4'h4, {26'h0, 1'b1, 1'b0, bidir, 3'h0}, 2'h0);
    rd(4'h4, 2'h0); chk(32'(d[3]), 32'(bidir));
    @(posedge aclk) end_init_instr <= 1;
    @(posedge aclk) end_init_instr <= 0;
    @(posedge aclk);
    chk({31'h0, reset_out_n}, 32'h1);
    chk({31'h0, powerdown_delay_pullup}, 32'h1);
    // late write of the enable must be ignored either way
    wr(4'h4, {26'h0, 1'b1, 1'b0, !bidir, 3'h0}, 2'h0);
    rd(4'h4, 2'h0); chk(32'(d[3]), 32'(bidir));
    config_port <= cp; external_access_pin <= ~external_access_pin; pll_bypass <= (how == 2);
    @(posedge aclk);
    if (how < 2) begin
      sw_reset_req <= (how == 0); wdt_reset_req <= (how == 1);
      @(posedge aclk) begin sw_reset_req <= 0; wdt_reset_req <= 0; end
    end else button_n <= 0;
    repeat (4) @(posedge aclk);
    chk({31'h0, reset_out_n}, 32'h0);
    chk({31'h0, reset_in_n_drv.oe}, 32'(bidir));
    repeat (how == 3 ? 596 : 6) @(posedge aclk);
    button_n <= 1;
    wait_done;
    // software-type latch also wipes bits 5..2
    exp_cfg = (exp_cfg & ~mask & ~(mask == 16'h1FC0 ? 16'h003C : 16'h0000)) | (cp & mask);
    check_all(st, 32'hF);
  endtask : run
  // watchdog on a hung run
  initial begin
    #(4 * 40000);
    n_errors++;
    end_of_test;
  end
  // main sequence
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1;
    wait_done;
    exp_cfg = 16'hF0FF;
    check_all(4'h1, 32'h7);
    cap_high <= 1'b1; // capacitor charged for the warm resets
    wr(4'h2, 32'h0, 2'h2);
    rd(4'h2, 2'h2); chk(d, 32'h0);
    run(0, 0, 16'h5A3C, 16'h1FC0, 4'h4);
    run(1, 0, 16'hC3A5, 16'h1FC0, 4'h4);
    run(0, 1, 16'h3C5A, 16'h1FFF, 4'h2);
    run(2, 0, 16'hA55A, 16'h1FFF, 4'h2);
    run(3, 0, 16'h5AA5, 16'hFFFF, 4'hA);
    // delay pin low during a short press turns it asynchronous
    cap_high <= 1'b0;
    run(2, 0, 16'h0FF0, 16'h1FFF, 4'h3);
    end_of_test;
  end
endmodule : reset_pin_config_latch_test

/* File: rst_cfg_pkg.sv */
// package: constants, field positions and types for the reset pin and configuration latch
package rst_cfg_pkg;

  // timing, in half_clock_period units as printed, and the cpu clock ratio
  localparam int TCL_PER_CLK = 2;
  localparam int SEQ_TCL = 1024;
  localparam int LONG_TCL = 1040;
  localparam int LATCH_TCL = 8;
  localparam int LATCH_BYP_TCL = 6;
  localparam logic [9:0] SEQ_CYCLES = 10'(SEQ_TCL / TCL_PER_CLK);
  localparam logic [9:0] LONG_CYCLES = 10'(LONG_TCL / TCL_PER_CLK);
  localparam logic [9:0] LATCH_CYCLES = 10'(LATCH_TCL / TCL_PER_CLK);
  localparam logic [9:0] LATCH_BYP_CYCLES = 10'(LATCH_BYP_TCL / TCL_PER_CLK);
  // wait after the pull-down is dropped so the pin and its synchroniser settle
  localparam logic [9:0] SETTLE_CYCLES = 10'h004;

  // register byte offsets
  localparam logic [3:0] OFS_LATCHED_CONFIG = 4'h0;
  localparam logic [3:0] OFS_SYSTEM_CONFIG = 4'h4;
  localparam logic [3:0] OFS_BUS_CONFIG0 = 4'h8;
  localparam logic [3:0] OFS_RESET_STATUS = 4'hC;

  // system_config_reg fields
  localparam int SYS_BIDIR_BIT = 3;
  localparam int SYS_PWD_BIT = 5;
  localparam int SYS_WRITE_SIGNAL_CONFIG_BIT = 7;
  localparam int SYS_BYTE_HIGH_DISABLE_BIT = 9;
  // bus_config_reg0 fields
  localparam int BUS_TYPE_LSB = 6;
  localparam int BUS_LATCH_BIT = 9;
  localparam int BUS_ACTIVE_BIT = 10;
  // reset_status fields
  localparam int STAT_ASYNC_BIT = 0;
  localparam int STAT_KIND_LSB = 1;
  localparam int STAT_LONG_BIT = 3;
  localparam int STAT_OUT_BIT = 4;
  localparam int STAT_PULL_BIT = 5;
  localparam int STAT_STATE_LSB = 8;

  // config_port bit positions (high byte is 15:8, low byte 7:0)
  localparam int CP_WRC_BIT = 8;
  localparam int CP_BYTE_HIGH_DISABLE_BIT = 9;
  localparam int CP_BUS_TYPE_PINS_LSB = 6;
  localparam int CP_WRITE_SIGNAL_CONFIG_BIT = 7;
  localparam int CP_BSL_BIT = 4;
  localparam int CP_ADP_BIT = 1;
  localparam int CP_EMU_BIT = 0;

  // sampling masks per reset kind, and bits cleared by software/watchdog resets
  localparam logic [15:0] MASK_ALL = 16'hFFFF;
  localparam logic [15:0] MASK_SHORT = 16'h1FFF;
  localparam logic [15:0] MASK_SW = 16'h1FC0;
  localparam logic [15:0] CLEAR_SW = 16'h003C;
  localparam logic [15:0] CFG_RESET = 16'h0000;

  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // sequencer states, one-hot
  typedef enum logic [4:0] {
    ST_SEQ = 5'h01,
    ST_EXTEND = 5'h02,
    ST_LATCH = 5'h04,
    ST_INIT = 5'h08,
    ST_RUN = 5'h10
  } seq_state_t;

  // source of the running reset
  typedef enum logic [1:0] {
    KIND_POR = 2'h0,
    KIND_HW = 2'h1,
    KIND_SW = 2'h2
  } reset_kind_t;

  // latched settings routed to other blocks
  typedef struct packed {
    logic [2:0] clock_config_field;
    logic [1:0] segment_addr_select;
    logic [1:0] chip_select_count;
    logic bootstrap_select;
    logic adapt_mode_select;
    logic debug_host_mode_select;
  } cfg_route_t;

  // one open-drain pin, driver side
  typedef struct packed {
    logic o;
    logic oe;
  } od_pin_t;

endpackage : rst_cfg_pkg
